// File: lcell_regs.svh
// constants for the logic cell and its group, pin and global logic
// assumes inclusion by lcell_top only
//
// Function
// - each cell evaluates any boolean function of four inputs by table.
// - the cell register only captures table or counter data while its own clock enable is high.
// - in counter mode the cascade input becomes a synchronous clear.
// - in counter mode the table splits into a data half and a carry half.
// - counter load picks count or load data, then clear forces zero.
// - the emulated bus reads low when several drivers are enabled.
// - the emulated bus reads high when none is enabled, built as a mux.
// - the asynchronous clear comes from group line a or b by choice, always from b in load and clear mode.
// - asynchronous load puts the fourth data input in at once on line a.
// - clear and preset are active low and unused ones sit high.
// - six asynchronous control modes are offered.
// - global lines come from dedicated pins or internal peripheral logic.
// - when enabled, a low chip output enable floats every device output.
// - the chip reset also resets the pin cell registers.
// - four group lines, each with its own inversion, serve all cells.
`ifndef LCELL_REGS_SVH
`define LCELL_REGS_SVH

// ---------------------------------------------------------------------------
// widths and reset values
// ---------------------------------------------------------------------------
`define LCELL_LUT_W       16
`define LCELL_HALF_W      8
`define LCELL_CARRY_BASE  4'h8
`define LCELL_GLOBAL_N    4
`define LCELL_GROUP_N     4
`define LCELL_Q_RST       1'h0
`define LCELL_PIN_RST     1'h0
`define LCELL_BUS_IDLE    1'h1
`define LCELL_BUS_FIGHT   1'h0
`define LCELL_GLOBAL_RST  4'h0
`define LCELL_SYNC_RST    3'h0
`define LCELL_OE_SYNC_RST 3'h7
`define LCELL_OE_RST      1'h1
`define LCELL_CRST_RST    1'h0
`define LCELL_GROUP_RST   4'h0

`endif

// File: lcell_pkg.sv
// types shared by the logic cell top and its bench
// assumes nothing beyond a SystemVerilog compiler
package lcell_pkg;

  // ---------------------------------------------------------------------------
  // asynchronous control modes
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    LCELL_ASY_CLR,
    LCELL_ASY_PRE,
    LCELL_ASY_CLR_PRE,
    LCELL_ASY_LOAD_CLR,
    LCELL_ASY_LOAD_PRE,
    LCELL_ASY_LOAD_NONE
  } lcell_asy_mode_t;

  // ---------------------------------------------------------------------------
  // static configuration of one cell, its group and the chip options
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0]     lut_mask;
    logic            counter_mode;
    lcell_asy_mode_t asy_mode;
    logic            clr_from_b;
    logic [3:0]      group_invert;
    logic [3:0]      global_from_int;
    logic            oe_ctrl_enable;
  } lcell_cfg_t;

endpackage : lcell_pkg

// File: lcell_top.sv
// logic cell with register controls, group lines, bus emulation,
// global line select, chip output enable and pin cell registers
// assumes cfg_i is static while running; pins are asynchronous to clk_sys_i
`include "lcell_regs.svh"

module lcell_top #(
  parameter int BUS_N = 4,
  parameter int PIN_N = 8
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_b_i,
  input  wire logic                 clk_en_i,
  input  wire lcell_pkg::lcell_cfg_t cfg_i,
  input  wire logic [3:0]           cell_data_i,
  input  wire logic                 cell_ena_i,
  input  wire logic                 sync_load_i,
  input  wire logic                 cascade_in_i,
  input  wire logic                 carry_in_i,
  input  wire logic [3:0]           group_raw_i,
  input  wire logic [BUS_N-1:0]     bus_oe_i,
  input  wire logic [BUS_N-1:0]     bus_data_i,
  input  wire logic [3:0]           global_pin_i,
  input  wire logic [3:0]           global_int_i,
  input  wire logic                 chip_output_enable_i,
  input  wire logic                 chip_reset_b_i,
  input  wire logic [PIN_N-1:0]     pin_data_i,
  input  wire logic [PIN_N-1:0]     pin_oe_req_i,
  output logic                      cell_q_o,
  output logic                      cell_comb_o,
  output logic                      cascade_out_o,
  output logic                      carry_out_o,
  output logic [3:0]                group_line_o,
  output logic                      bus_o,
  output logic [3:0]                global_line_o,
  output logic [PIN_N-1:0]          pin_out_o,
  output logic [PIN_N-1:0]          pin_oe_o
);

  // ---------------------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------------------
  // bus driver count is held in seven bits
  if (BUS_N < 1 || BUS_N > 64 || PIN_N < 1)
  begin : g_par_chk
    $error("BUS_N must be 1 to 64 and PIN_N at least 1");
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic lut4(input logic [15:0] mask,
                                input logic [3:0]  sel);
    lut4 = mask[sel];
  endfunction

  // a change counts once stages two and three agree
  function automatic logic [3:0] settle(input logic [3:0] old_v,
                                       input logic [3:0] s2,
                                       input logic [3:0] s3);
    settle = (s2 & s3) | (old_v & (s2 | s3));
  endfunction

  // ---------------------------------------------------------------------------
  // pin synchronisers: three stages, stage one read by stage two only
  // ---------------------------------------------------------------------------
  logic [3:0] gpin_s1_ff;
  logic [3:0] gpin_s2_ff;
  logic [3:0] gpin_s3_ff;
  logic [3:0] gpin_ff;
  logic [2:0] oe_sync_ff;
  logic       oe_ff;
  logic [2:0] crst_sync_ff;
  logic       crst_b_ff;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      gpin_s1_ff <= `LCELL_GLOBAL_RST;
      gpin_s2_ff <= `LCELL_GLOBAL_RST;
      gpin_s3_ff <= `LCELL_GLOBAL_RST;
      gpin_ff    <= `LCELL_GLOBAL_RST;
    end
    else if (clk_en_i)
    begin
      gpin_s1_ff <= global_pin_i;
      gpin_s2_ff <= gpin_s1_ff;
      gpin_s3_ff <= gpin_s2_ff;
      gpin_ff    <= settle(gpin_ff, gpin_s2_ff, gpin_s3_ff);
    end
  end

  // output enable pin idles high so outputs are not floated once reset ends
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      oe_sync_ff   <= `LCELL_OE_SYNC_RST;
      oe_ff        <= `LCELL_OE_RST;
      crst_sync_ff <= `LCELL_SYNC_RST;
      crst_b_ff    <= `LCELL_CRST_RST;
    end
    else if (clk_en_i)
    begin
      oe_sync_ff   <= {oe_sync_ff[1:0], chip_output_enable_i};
      crst_sync_ff <= {crst_sync_ff[1:0], chip_reset_b_i};
      if (oe_sync_ff[1] == oe_sync_ff[2])
      begin
        oe_ff <= oe_sync_ff[2];
      end
      if (crst_sync_ff[1] == crst_sync_ff[2])
      begin
        crst_b_ff <= crst_sync_ff[2];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // group control lines with inversion
  // ---------------------------------------------------------------------------
  logic [3:0] grp;
  logic       group_ctrl_a;
  logic       group_ctrl_b;

  assign grp          = group_raw_i ^ cfg_i.group_invert;
  assign group_ctrl_a = grp[2];
  assign group_ctrl_b = grp[3];

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      group_line_o <= `LCELL_GROUP_RST;
    end
    else if (clk_en_i)
    begin
      group_line_o <= grp;
    end
  end

  // ---------------------------------------------------------------------------
  // asynchronous control decode
  // ---------------------------------------------------------------------------
  logic clr_line_b;
  logic other_line_b;
  logic asy_clr_b;
  logic asy_pre_b;
  logic asy_load;
  logic asy_act;
  logic asy_val;

  assign clr_line_b   = cfg_i.clr_from_b ? group_ctrl_b : group_ctrl_a;
  assign other_line_b = cfg_i.clr_from_b ? group_ctrl_a : group_ctrl_b;

  always_comb
  begin
    // unused clear and preset sit high, unused load sits low; none of them acts
    asy_clr_b = 1'h1;
    asy_pre_b = 1'h1;
    asy_load  = 1'h0;
    case (cfg_i.asy_mode)
      lcell_pkg::LCELL_ASY_CLR:
      begin
        asy_clr_b = clr_line_b;
      end
      lcell_pkg::LCELL_ASY_PRE:
      begin
        asy_pre_b = other_line_b;
      end
      lcell_pkg::LCELL_ASY_CLR_PRE:
      begin
        asy_clr_b = clr_line_b;
        asy_pre_b = other_line_b;
      end
      lcell_pkg::LCELL_ASY_LOAD_CLR:
      begin
        asy_load  = group_ctrl_a;
        asy_clr_b = group_ctrl_b;
      end
      lcell_pkg::LCELL_ASY_LOAD_PRE:
      begin
        asy_load  = group_ctrl_a;
        asy_pre_b = group_ctrl_b;
      end
      lcell_pkg::LCELL_ASY_LOAD_NONE:
      begin
        asy_load  = group_ctrl_a;
      end
      default:
      begin
        asy_load  = 1'h0;
      end
    endcase
  end

  // clear beats preset beats load
  assign asy_act = !asy_clr_b || !asy_pre_b || asy_load;
  assign asy_val = !asy_clr_b ? 1'h0 :
                   !asy_pre_b ? 1'h1 : cell_data_i[3];

  // ---------------------------------------------------------------------------
  // table and counter datapath
  // ---------------------------------------------------------------------------
  logic q_ff;
  logic lut_out;
  logic cnt_sum;
  logic cnt_carry;
  logic cnt_next;
  logic nxt_q;

  assign lut_out   = lut4(cfg_i.lut_mask, cell_data_i);
  // counter halves read data bit 0, the register output and carry in
  assign cnt_sum   = lut4(cfg_i.lut_mask,
                          {1'h0, carry_in_i, cell_data_i[0], q_ff});
  assign cnt_carry = lut4(cfg_i.lut_mask,
                          `LCELL_CARRY_BASE |
                          {1'h0, carry_in_i, cell_data_i[0], q_ff});
  // cascade input serves as an active-low synchronous clear here
  assign cnt_next  = (sync_load_i ? cell_data_i[2] : cnt_sum)
                     & cascade_in_i;
  assign nxt_q     = cfg_i.counter_mode ? cnt_next : lut_out;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i || !crst_b_ff)
    begin
      q_ff <= `LCELL_Q_RST;
    end
    else if (clk_en_i)
    begin
      if (asy_act)
      begin
        q_ff <= asy_val;
      end
      else if (cell_ena_i)
      begin
        q_ff <= nxt_q;
      end
    end
  end

  // async controls show at once, not a cycle late
  assign cell_q_o = asy_act ? asy_val : q_ff;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      cell_comb_o   <= 1'h0;
      cascade_out_o <= 1'h0;
      carry_out_o   <= 1'h0;
    end
    else if (clk_en_i)
    begin
      cell_comb_o   <= lut_out;
      cascade_out_o <= cfg_i.counter_mode ? 1'h0 : (lut_out & cascade_in_i);
      carry_out_o   <= cfg_i.counter_mode ? cnt_carry : 1'h0;
    end
  end

  // ---------------------------------------------------------------------------
  // emulated internal bus: a mux, never a floating wire
  // ---------------------------------------------------------------------------
  logic [6:0] drv_cnt;
  logic       nxt_bus;

  always_comb
  begin
    drv_cnt = 7'($countones(bus_oe_i));
    if (drv_cnt == 7'h00)
    begin
      nxt_bus = `LCELL_BUS_IDLE;
    end
    else if (drv_cnt != 7'h01)
    begin
      nxt_bus = `LCELL_BUS_FIGHT;
    end
    else
    begin
      nxt_bus = |(bus_oe_i & bus_data_i);
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      bus_o <= `LCELL_BUS_IDLE;
    end
    else if (clk_en_i)
    begin
      bus_o <= nxt_bus;
    end
  end

  // ---------------------------------------------------------------------------
  // global lines: pin or internal source per line
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      global_line_o <= `LCELL_GLOBAL_RST;
    end
    else if (clk_en_i)
    begin
      global_line_o <= (cfg_i.global_from_int & global_int_i)
                     | (~cfg_i.global_from_int & gpin_ff);
    end
  end

  // ---------------------------------------------------------------------------
  // pin cell registers and chip output enable
  // ---------------------------------------------------------------------------
  logic float_all;

  assign float_all = cfg_i.oe_ctrl_enable && !oe_ff;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i || !crst_b_ff)
    begin
      pin_out_o <= {PIN_N{`LCELL_PIN_RST}};
      pin_oe_o  <= {PIN_N{1'h0}};
    end
    else if (clk_en_i)
    begin
      pin_out_o <= pin_data_i;
      pin_oe_o  <= float_all ? {PIN_N{1'h0}} : pin_oe_req_i;
    end
  end

endmodule // lcell_top

// File: lcell_top_sva.sv
// assertions on the logic cell top, port view only
// assumes the bind below and a cfg_i that is static between scenarios
module lcell_top_sva #(
  parameter int BUS_N = 4,
  parameter int PIN_N = 8
) (
  input wire logic                  clk_sys_i,
  input wire logic                  rst_b_i,
  input wire logic                  clk_en_i,
  input wire lcell_pkg::lcell_cfg_t cfg_i,
  input wire logic [3:0]            cell_data_i,
  input wire logic                  cell_ena_i,
  input wire logic                  cascade_in_i,
  input wire logic [3:0]            group_raw_i,
  input wire logic [BUS_N-1:0]      bus_oe_i,
  input wire logic [BUS_N-1:0]      bus_data_i,
  input wire logic                  chip_output_enable_i,
  input wire logic                  cell_q_o,
  input wire logic                  cell_comb_o,
  input wire logic                  bus_o,
  input wire logic [PIN_N-1:0]      pin_oe_o
);
  // ----------
  // helpers
  // ----------
  logic ln_a;
  logic ln_b;
  logic quiet;
  logic lut_now;
  logic one_pass;
  assign ln_a = group_raw_i[2] ^ cfg_i.group_invert[2];
  assign ln_b = group_raw_i[3] ^ cfg_i.group_invert[3];
  // clear-only mode with idle lines: nothing async acts
  assign quiet = cfg_i.asy_mode == lcell_pkg::LCELL_ASY_CLR && ln_a && ln_b;
  assign lut_now = cfg_i.lut_mask[cell_data_i];
  assign one_pass = |(bus_oe_i & bus_data_i);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  // ----------
  // assertions
  // ----------
  a_bus_idle_high: assert property (
    clk_en_i && bus_oe_i == '0 |=> bus_o == 1'h1)
    else $error("bus not high with no driver");
  a_bus_fight_low: assert property (
    clk_en_i && $countones(bus_oe_i) > 1 |=> bus_o == 1'h0)
    else $error("bus not low with several drivers");
  a_bus_one_pass: assert property (
    clk_en_i && $onehot(bus_oe_i) |=> bus_o == $past(one_pass))
    else $error("single driver data lost");
  a_lut_any_func: assert property (
    clk_en_i && !cfg_i.counter_mode |=> cell_comb_o == $past(lut_now))
    else $error("table output wrong");
  // a line that acts one cycle on may override the held value legally
  a_ena_hold_q: assert property (
    clk_en_i && !cell_ena_i && quiet ##1 quiet |-> $stable(cell_q_o))
    else $error("register moved without enable");
  a_async_load: assert property (
    cfg_i.asy_mode == lcell_pkg::LCELL_ASY_LOAD_NONE && ln_a
    |-> cell_q_o == cell_data_i[3])
    else $error("async load not immediate");
  a_async_clear: assert property (
    cfg_i.asy_mode == lcell_pkg::LCELL_ASY_CLR
    && !(cfg_i.clr_from_b ? ln_b : ln_a) |-> cell_q_o == 1'h0)
    else $error("async clear not immediate");
  a_async_preset: assert property (
    cfg_i.asy_mode == lcell_pkg::LCELL_ASY_PRE
    && !(cfg_i.clr_from_b ? ln_a : ln_b) |-> cell_q_o == 1'h1)
    else $error("async preset not immediate");
  a_sync_clear: assert property (
    clk_en_i && cfg_i.counter_mode && cell_ena_i && !cascade_in_i && quiet
    ##1 quiet |-> cell_q_o == 1'h0)
    else $error("counter clear did not zero");
  // pin path is slow: eight cycles cover sync and output register
  a_oe_float: assert property (
    (clk_en_i && cfg_i.oe_ctrl_enable && !chip_output_enable_i) [*8]
    |-> pin_oe_o == '0)
    else $error("outputs still driven");
endmodule // lcell_top_sva

bind lcell_top lcell_top_sva #(.BUS_N(BUS_N), .PIN_N(PIN_N)) lcell_top_sva_i (
  .clk_sys_i, .rst_b_i, .clk_en_i, .cfg_i, .cell_data_i, .cell_ena_i,
  .cascade_in_i, .group_raw_i, .bus_oe_i, .bus_data_i, .chip_output_enable_i,
  .cell_q_o, .cell_comb_o, .bus_o, .pin_oe_o);

// File: lcell_tb.sv
// self-checking bench for the logic cell top
// assumes lcell_pkg, lcell_top and its bound checker are compiled first
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk_sys_i = 1'h0;
  logic                  rst_b_i = 1'h0;
  logic                  clk_en_i = 1'h1;
  lcell_pkg::lcell_cfg_t cfg_i = '0;
  logic [3:0]            cell_data_i = 4'h0;
  logic                  cell_ena_i = 1'h0;
  logic                  sync_load_i = 1'h0;
  logic                  cascade_in_i = 1'h1;
  logic                  carry_in_i = 1'h0;
  logic [3:0]            group_raw_i = 4'hC;
  logic [3:0]            bus_oe_i = 4'h0;
  logic [3:0]            bus_data_i = 4'h0;
  logic [3:0]            global_pin_i = 4'h0;
  logic [3:0]            global_int_i = 4'h0;
  logic                  chip_output_enable_i = 1'h1;
  logic                  chip_reset_b_i = 1'h1;
  logic [7:0]            pin_data_i = 8'h00;
  logic [7:0]            pin_oe_req_i = 8'h00;
  logic                  cell_q_o, cell_comb_o, cascade_out_o, carry_out_o;
  logic                  bus_o;
  logic [3:0]            group_line_o, global_line_o;
  logic [7:0]            pin_out_o, pin_oe_o;
  logic [15:0]           seed = 16'h46D2;
  logic [15:0]           r;
  logic                  e_q, e_c, act, ca, pa;
  int                    n_mismatch = 0;
  int                    tests_run = 0;
  int                    mq;

  lcell_top #(.BUS_N(4), .PIN_N(8)) lcell_top_i (.clk_sys_i, .rst_b_i,
    .clk_en_i, .cfg_i, .cell_data_i, .cell_ena_i, .sync_load_i,
    .cascade_in_i, .carry_in_i, .group_raw_i, .bus_oe_i, .bus_data_i,
    .global_pin_i, .global_int_i, .chip_output_enable_i, .chip_reset_b_i,
    .pin_data_i, .pin_oe_req_i, .cell_q_o, .cell_comb_o, .cascade_out_o,
    .carry_out_o, .group_line_o, .bus_o, .global_line_o, .pin_out_o,
    .pin_oe_o);

  always #5 clk_sys_i = ~clk_sys_i;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // let n edges pass, then sample away from the edge
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask

  // run needs under two hundred cycles; fifteen times that is a hang
  initial
  begin
    repeat (3000) @(posedge clk_sys_i);
    n_mismatch++;
    final_report();
  end

  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    rst_b_i <= 1'h1;
    settle(6);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk_sys_i);
      r = lfsr(seed);
      seed = lfsr(r);
      cfg_i.lut_mask <= r;
      cfg_i.group_invert <= 4'h6;
      cfg_i.global_from_int <= 4'hF;
      cell_data_i <= i[3:0];
      {bus_oe_i, bus_data_i, global_int_i, group_raw_i} <= seed;
      e_q = (seed[15:12] == 4'h0) | (($countones(seed[15:12]) == 1)
        & |(seed[15:12] & seed[11:8]));
      settle(1);
      check(8'(cell_comb_o), 8'(r[i]));
      check(8'(cascade_out_o), 8'(r[i]));
      check(8'(bus_o), 8'(e_q));
      check(8'(global_line_o), 8'(seed[7:4]));
      check(8'(group_line_o), 8'(seed[3:0] ^ 4'h6));
    end
    $display("table and bus test done");
    @(posedge clk_sys_i);
    cfg_i.group_invert <= 4'h0;
    group_raw_i <= 4'hC;
    cfg_i.lut_mask <= 16'h8000;
    cell_data_i <= 4'hF;
    cell_ena_i <= 1'h1;
    settle(1);
    check(8'(cell_q_o), 8'h01);
    @(posedge clk_sys_i);
    cell_ena_i <= 1'h0;
    cfg_i.lut_mask <= 16'h0000;
    settle(2);
    check(8'(cell_q_o), 8'h01);
    check(8'(cell_comb_o), 8'h00);
    @(posedge clk_sys_i);
    clk_en_i <= 1'h0;
    cfg_i.lut_mask <= 16'hFFFF;
    settle(2);
    check(8'(cell_comb_o), 8'h00);
    $display("enable test done");
    @(posedge clk_sys_i);
    clk_en_i <= 1'h1;
    cell_ena_i <= 1'h1;
    cfg_i.counter_mode <= 1'h1;
    mq = 1;
    for (int i = 0; i < 24; i++)
    begin
      @(posedge clk_sys_i);
      seed = lfsr(seed);
      r = lfsr(seed);
      cfg_i.lut_mask <= r;
      {carry_in_i, cell_data_i[0], cell_data_i[2], sync_load_i} <= seed[3:0];
      cascade_in_i <= |seed[6:4];
      e_c = r[{1'h1, seed[3], seed[2], mq[0]}];
      e_q = (seed[0] ? seed[1] : r[{1'h0, seed[3], seed[2], mq[0]}])
        & |seed[6:4];
      settle(1);
      // inputs stand one more edge, so the cell steps again before new ones
      mq = int'((seed[0] ? seed[1] : r[{1'h0, seed[3], seed[2], e_q}])
        & |seed[6:4]);
      check(8'(cell_q_o), 8'(e_q));
      check(8'(carry_out_o), 8'(e_c));
      check(8'(cascade_out_o), 8'h00);
    end
    $display("counter test done");
    @(posedge clk_sys_i);
    cfg_i.counter_mode <= 1'h0;
    cascade_in_i <= 1'h1;
    cell_ena_i <= 1'h0;
    for (int m = 0; m < 24; m++)
    begin
      @(posedge clk_sys_i);
      seed = lfsr(seed);
      cfg_i.asy_mode <= lcell_pkg::lcell_asy_mode_t'(m / 4);
      cfg_i.clr_from_b <= seed[0];
      cell_data_i[3] <= seed[1];
      group_raw_i <= {m[1:0], 2'h0};
      ca = seed[0] ? m[1] : m[0];
      pa = seed[0] ? m[0] : m[1];
      case (m / 4)
        0: {act, e_q} = {~ca, 1'h0};
        1: {act, e_q} = {~pa, 1'h1};
        2: {act, e_q} = {~(ca & pa), ca};
        3: {act, e_q} = {~m[1] | m[0], m[1] & seed[1]};
        4: {act, e_q} = {~m[1] | m[0], ~m[1] | seed[1]};
        default: {act, e_q} = {m[0], seed[1]};
      endcase
      @(negedge clk_sys_i);
      if (act)
        check(8'(cell_q_o), 8'(e_q));
    end
    $display("async control test done");
    @(posedge clk_sys_i);
    cfg_i.asy_mode <= lcell_pkg::LCELL_ASY_CLR;
    group_raw_i <= 4'hC;
    cfg_i.global_from_int <= 4'h0;
    global_pin_i <= 4'hA;
    cfg_i.oe_ctrl_enable <= 1'h1;
    pin_data_i <= 8'h5A;
    pin_oe_req_i <= 8'hFF;
    cfg_i.lut_mask <= 16'hFFFF;
    cell_ena_i <= 1'h1;
    settle(8);
    check(8'(global_line_o), 8'h0A);
    check(pin_oe_o, 8'hFF);
    @(posedge clk_sys_i);
    chip_reset_b_i <= 1'h0;
    settle(8);
    check(pin_out_o, 8'h00);
    check(8'(cell_q_o), 8'h00);
    @(posedge clk_sys_i);
    chip_reset_b_i <= 1'h1;
    settle(8);
    check(pin_out_o, 8'h5A);
    @(posedge clk_sys_i);
    chip_output_enable_i <= 1'h0;
    settle(8);
    check(pin_oe_o, 8'h00);
    @(posedge clk_sys_i);
    cfg_i.oe_ctrl_enable <= 1'h0;
    settle(8);
    check(pin_oe_o, 8'hFF);
    $display("pin and chip control test done");
    final_report();
  end
endmodule // tb
